// *** shared/opsr_pkg.sv ***
// Package with constants and types for the operation status register group.
package opsr_pkg;
  typedef logic [15:0] opsr_word_t;
  typedef enum logic [1:0] {
    OPSR_SEL_COND,
    OPSR_SEL_EVENT,
    OPSR_SEL_ENABLE,
    OPSR_SEL_NONE
  } opsr_sel_e;
  localparam int OPSR_BIT_FAULT = 13;
  localparam int OPSR_BIT_CLOSED = 11;
  localparam int OPSR_BIT_REMOTE = 10;
  localparam int OPSR_BIT_TRIG = 5;
  localparam int OPSR_BIT_SCAN = 4;
  localparam opsr_word_t OPSR_USED_MASK = 16'h2c30;
  localparam opsr_word_t OPSR_ENABLE_RESET = 16'h0000;
  localparam opsr_word_t OPSR_EVENT_RESET = 16'h0000;
  localparam opsr_word_t OPSR_DATA_RESET = 16'h0000;
  localparam logic [2:0] OPSR_SYNC_RESET = 3'h0;
endpackage

// *** hw/opsr_core.sv ***
// Operation status register group: condition, latched event and enable mask.
//
// Overview of operation
// - Condition query returns the live flags as a 16-bit value.
// - Unassigned bit positions read zero in condition and event registers.
// - Flags sit at bits 13, 11, 10, 5 and 4; remote reads 1024.
// - Event query returns latched flags with the condition layout.
// - Controller writes a 16-bit enable mask; device stores and returns it.
// - Enable mask is zero after power-on reset.
// - Enable readback forces unassigned bit positions to zero.
`timescale 1ns/10ps
module opsr_core
  import opsr_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic fault_flag,
  input wire logic relay_closed_flag,
  input wire logic remote_state_flag,
  input wire logic trigger_pending_flag,
  input wire logic scan_running_flag,
  input wire opsr_pkg::opsr_sel_e query_sel,
  input wire logic query_strobe,
  input wire logic enable_write,
  input wire opsr_pkg::opsr_word_t enable_data,
  output opsr_pkg::opsr_word_t query_data,
  output logic query_valid,
  output opsr_pkg::opsr_word_t enable_mask
);
  import opsr_pkg::*;

  logic [2:0] sync_fault_r, sync_closed_r, sync_remote_r, sync_trig_r, sync_scan_r;
  opsr_word_t cond_r;
  opsr_word_t cond_nxt;
  opsr_word_t prev_cond_r;
  opsr_word_t event_r;
  opsr_word_t enable_r;
  opsr_word_t query_data_r;
  logic query_valid_r;
  logic event_read;

  // Three-stage input synchronisers.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync_fault_r <= OPSR_SYNC_RESET;
      sync_closed_r <= OPSR_SYNC_RESET;
      sync_remote_r <= OPSR_SYNC_RESET;
      sync_trig_r <= OPSR_SYNC_RESET;
      sync_scan_r <= OPSR_SYNC_RESET;
    end else begin
      sync_fault_r <= {sync_fault_r[1:0], fault_flag};
      sync_closed_r <= {sync_closed_r[1:0], relay_closed_flag};
      sync_remote_r <= {sync_remote_r[1:0], remote_state_flag};
      sync_trig_r <= {sync_trig_r[1:0], trigger_pending_flag};
      sync_scan_r <= {sync_scan_r[1:0], scan_running_flag};
    end
  end

  always_comb begin
    cond_nxt = cond_r;
    if (sync_fault_r[1] == sync_fault_r[2]) cond_nxt[OPSR_BIT_FAULT] = sync_fault_r[2];
    if (sync_closed_r[1] == sync_closed_r[2]) cond_nxt[OPSR_BIT_CLOSED] = sync_closed_r[2];
    if (sync_remote_r[1] == sync_remote_r[2]) cond_nxt[OPSR_BIT_REMOTE] = sync_remote_r[2];
    if (sync_trig_r[1] == sync_trig_r[2]) cond_nxt[OPSR_BIT_TRIG] = sync_trig_r[2];
    if (sync_scan_r[1] == sync_scan_r[2]) cond_nxt[OPSR_BIT_SCAN] = sync_scan_r[2];
    cond_nxt = cond_nxt & OPSR_USED_MASK;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cond_r <= OPSR_EVENT_RESET;
      prev_cond_r <= OPSR_EVENT_RESET;
    end else begin
      cond_r <= cond_nxt;
      prev_cond_r <= cond_r;
    end
  end

  assign event_read = query_strobe && (query_sel == OPSR_SEL_EVENT);

  // Latch rising flags; a new rise wins over the read clear.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      event_r <= OPSR_EVENT_RESET;
    end else begin
      event_r <= ((event_read ? OPSR_EVENT_RESET : event_r) | (cond_r & ~prev_cond_r)) & OPSR_USED_MASK;
    end
  end

  // Enable mask store, zero at reset.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      enable_r <= OPSR_ENABLE_RESET;
    end else if (enable_write) begin
      enable_r <= enable_data;
    end
  end

  // Query answer one cycle after the strobe.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      query_data_r <= OPSR_DATA_RESET;
      query_valid_r <= 1'b0;
    end else begin
      query_valid_r <= query_strobe;
      if (query_strobe) begin
        unique case (query_sel)
          OPSR_SEL_COND: query_data_r <= cond_r;
          OPSR_SEL_EVENT: query_data_r <= event_r;
          OPSR_SEL_ENABLE: query_data_r <= enable_r & OPSR_USED_MASK;
          OPSR_SEL_NONE: query_data_r <= OPSR_DATA_RESET;
        endcase
      end
    end
  end

  assign query_data = query_data_r;
  assign query_valid = query_valid_r;
  assign enable_mask = enable_r & OPSR_USED_MASK;

  property p_cond_read;
    @(posedge clock) disable iff (!nrst)
      query_strobe && query_sel == OPSR_SEL_COND |=> query_valid && query_data == $past(cond_r);
  endproperty
  a_cond_read: assert property (p_cond_read) else $error("Condition read wrong.");

  property p_unused_zero;
    @(posedge clock) disable iff (!nrst)
      ((cond_r | event_r) & ~OPSR_USED_MASK) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unused bit set.");

  property p_remote_pos;
    @(posedge clock) disable iff (!nrst)
      sync_remote_r[2] && sync_remote_r[1] |=> cond_r[OPSR_BIT_REMOTE];
  endproperty
  a_remote_pos: assert property (p_remote_pos) else $error("Remote bit misplaced.");

  sequence s_rise;
    !prev_cond_r[OPSR_BIT_FAULT] && cond_r[OPSR_BIT_FAULT];
  endsequence
  property p_event_latch;
    @(posedge clock) disable iff (!nrst)
      s_rise ##1 !event_read |=> event_r[OPSR_BIT_FAULT];
  endproperty
  a_event_latch: assert property (p_event_latch) else $error("Event not latched.");

  property p_event_read;
    @(posedge clock) disable iff (!nrst)
      query_strobe && query_sel == OPSR_SEL_EVENT |=> query_data == $past(event_r);
  endproperty
  a_event_read: assert property (p_event_read) else $error("Event read wrong.");

  property p_enable_store;
    @(posedge clock) disable iff (!nrst)
      enable_write |=> enable_mask == ($past(enable_data) & OPSR_USED_MASK);
  endproperty
  a_enable_store: assert property (p_enable_store) else $error("Mask not stored.");

  property p_enable_reset;
    @(posedge clock) !nrst |=> enable_mask == 16'h0000;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("Mask not cleared.");

  property p_enable_read;
    @(posedge clock) disable iff (!nrst)
      query_strobe && query_sel == OPSR_SEL_ENABLE |=> query_data == ($past(enable_r) & OPSR_USED_MASK);
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("Mask readback unmasked.");

  property p_valid_pulse;
    @(posedge clock) disable iff (!nrst)
      query_strobe |=> query_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("Answer missing.");

  property p_valid_quiet;
    @(posedge clock) disable iff (!nrst)
      !query_strobe |=> !query_valid;
  endproperty
  a_valid_quiet: assert property (p_valid_quiet) else $error("Answer without query.");

  property p_fault_pos;
    @(posedge clock) disable iff (!nrst)
      sync_fault_r[2] == sync_fault_r[1] |=> cond_r[OPSR_BIT_FAULT] == $past(sync_fault_r[2]);
  endproperty
  a_fault_pos: assert property (p_fault_pos) else $error("Fault bit misplaced.");

  property p_closed_pos;
    @(posedge clock) disable iff (!nrst)
      sync_closed_r[2] == sync_closed_r[1] |=> cond_r[OPSR_BIT_CLOSED] == $past(sync_closed_r[2]);
  endproperty
  a_closed_pos: assert property (p_closed_pos) else $error("Relay bit misplaced.");

  property p_trig_pos;
    @(posedge clock) disable iff (!nrst)
      sync_trig_r[2] == sync_trig_r[1] |=> cond_r[OPSR_BIT_TRIG] == $past(sync_trig_r[2]);
  endproperty
  a_trig_pos: assert property (p_trig_pos) else $error("Trigger bit misplaced.");

  property p_scan_pos;
    @(posedge clock) disable iff (!nrst)
      sync_scan_r[2] == sync_scan_r[1] |=> cond_r[OPSR_BIT_SCAN] == $past(sync_scan_r[2]);
  endproperty
  a_scan_pos: assert property (p_scan_pos) else $error("Scan bit misplaced.");

  sequence s_read_quiet;
    event_read && ((cond_r & ~prev_cond_r) == 16'h0000);
  endsequence
  property p_event_clear;
    @(posedge clock) disable iff (!nrst)
      s_read_quiet |=> event_r == 16'h0000;
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("Event not cleared by read.");

  property p_event_hold;
    @(posedge clock) disable iff (!nrst)
      !event_read |=> (event_r & $past(event_r)) == $past(event_r);
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("Event bit lost without read.");

  property p_mask_hold;
    @(posedge clock) disable iff (!nrst)
      !enable_write |=> $stable(enable_mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("Mask changed without write.");
endmodule

// *** sim/opsr_ctl.sv ***
// Remote controller model issuing status queries and mask writes.
`timescale 1ns/10ps
module opsr_ctl
  import opsr_pkg::*;
(
  input wire logic clock,
  output opsr_pkg::opsr_sel_e query_sel,
  output logic query_strobe,
  output logic enable_write,
  output opsr_pkg::opsr_word_t enable_data
);
  import opsr_pkg::*;
  initial begin
    query_sel = OPSR_SEL_NONE;
    query_strobe = 1'b0;
    enable_write = 1'b0;
    enable_data = 16'h0000;
  end
  task automatic send(input opsr_sel_e s, input logic w, input opsr_word_t d);
    @(negedge clock);
    query_sel = s;
    query_strobe = !w;
    enable_write = w;
    enable_data = d;
    @(negedge clock);
    query_strobe = 1'b0;
    enable_write = 1'b0;
    enable_data = ~d;
  endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the operation status register group.
`timescale 1ns/10ps
module tb;
  import opsr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] fl = 5'h00;
  logic [4:0] p;
  opsr_sel_e query_sel;
  logic query_strobe, enable_write, query_valid;
  opsr_word_t enable_data, query_data, enable_mask;
  opsr_word_t r = 16'h73bd;
  opsr_word_t expq[$];
  int n_mismatch = 0;
  int comparisons = 0;
  initial forever #5 clock = ~clock;
  opsr_core opsr_core_inst(.clock(clock), .nrst(nrst), .fault_flag(fl[4]), .relay_closed_flag(fl[3]),
    .remote_state_flag(fl[2]), .trigger_pending_flag(fl[1]), .scan_running_flag(fl[0]), .query_sel(query_sel),
    .query_strobe(query_strobe), .enable_write(enable_write), .enable_data(enable_data),
    .query_data(query_data), .query_valid(query_valid), .enable_mask(enable_mask));
  opsr_ctl opsr_ctl_inst(.clock(clock), .query_sel(query_sel), .query_strobe(query_strobe),
    .enable_write(enable_write), .enable_data(enable_data));
  function automatic opsr_word_t lfsr(opsr_word_t v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic opsr_word_t lay(logic [4:0] f);
    return {2'b00, f[4], 1'b0, f[3], f[2], 4'h0, f[1], f[0], 4'h0};
  endfunction
  task automatic check(opsr_word_t seen, opsr_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ask(opsr_sel_e s, opsr_word_t e);
    expq.push_back(e);
    opsr_ctl_inst.send(s, 1'b0, 16'h0000);
  endtask
  task automatic put_flags(logic [4:0] f);
    @(negedge clock);
    fl = f;
    repeat (8) @(negedge clock);
  endtask
  task automatic wrap_up;
    if (expq.size() != 0) n_mismatch++;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge clock) begin
    if (query_valid === 1'b1) check(query_data, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
  end
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    ask(OPSR_SEL_COND, 16'h0000);
    ask(OPSR_SEL_EVENT, 16'h0000);
    ask(OPSR_SEL_ENABLE, 16'h0000);
    ask(OPSR_SEL_NONE, 16'h0000);
    check(enable_mask, 16'h0000);
    $display("test reset done");
    opsr_ctl_inst.send(OPSR_SEL_NONE, 1'b1, 16'hffff);
    ask(OPSR_SEL_ENABLE, OPSR_USED_MASK);
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      opsr_ctl_inst.send(OPSR_SEL_NONE, 1'b1, r);
      check(enable_mask, r & 16'h2c30);
      ask(OPSR_SEL_ENABLE, r & 16'h2c30);
    end
    $display("test mask done");
    put_flags(5'b00100);
    ask(OPSR_SEL_COND, 16'h0400);
    ask(OPSR_SEL_EVENT, 16'h0400);
    ask(OPSR_SEL_EVENT, 16'h0000);
    put_flags(5'b00110);
    put_flags(5'b00100);
    ask(OPSR_SEL_COND, 16'h0400);
    ask(OPSR_SEL_EVENT, 16'h0020);
    $display("test latch done");
    p = 5'b00100;
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      put_flags(r[4:0]);
      ask(OPSR_SEL_COND, lay(r[4:0]));
      ask(OPSR_SEL_EVENT, lay(r[4:0] & ~p));
      p = r[4:0];
    end
    $display("test random flags done");
    opsr_ctl_inst.send(OPSR_SEL_NONE, 1'b1, 16'hffff);
    @(negedge clock);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    check(enable_mask, OPSR_ENABLE_RESET);
    ask(OPSR_SEL_ENABLE, 16'h0000);
    put_flags(p);
    ask(OPSR_SEL_COND, lay(p));
    ask(OPSR_SEL_EVENT, lay(p));
    $display("test second reset done");
    repeat (4) @(negedge clock);
    wrap_up();
  end
endmodule
